// file: rtl/ldoim_pkg.sv
// package: register map, field positions and reset values for the regulator mask and load meter
package ldoim_pkg;
  localparam logic [7:0] LDOIM_ADDR_MASK     = 8'h23;
  localparam logic [7:0] LDOIM_ADDR_SELECT   = 8'h24;
  localparam logic [7:0] LDOIM_ADDR_RES_HIGH = 8'h25;
  localparam logic [7:0] LDOIM_ADDR_RES_LOW  = 8'h26;
  localparam logic [7:0] LDOIM_ADDR_FLAGS    = 8'h27;
  localparam logic [7:0] LDOIM_ADDR_LIVE     = 8'h28;
  localparam logic [7:0] LDOIM_ADDR_TOPMASK  = 8'h29;
  // mask, select and result msb field positions
  localparam int LDOIM_B_L2_FALL = 7;
  localparam int LDOIM_B_L2_RISE = 6;
  localparam int LDOIM_B_L2_OC   = 4;
  localparam int LDOIM_B_L1_FALL = 3;
  localparam int LDOIM_B_L1_RISE = 2;
  localparam int LDOIM_B_L1_OC   = 0;
  localparam int LDOIM_B_SEL     = 0;
  localparam int LDOIM_B_MSB     = 0;
  // bit 0 reset is unspecified; zero chosen, reserved bits 5 and 1 read zero
  localparam logic [7:0] LDOIM_MASK_RESET = 8'hcc;
  localparam logic [7:0] LDOIM_MASK_WR    = 8'hdd;
  localparam logic [7:0] LDOIM_SEL_RESET  = 8'h00;
  // flag register bits: pg lin1, oc lin1, pg lin2, oc lin2, meter done
  localparam int LDOIM_F_L1_PG = 0;
  localparam int LDOIM_F_L1_OC = 1;
  localparam int LDOIM_F_L2_PG = 2;
  localparam int LDOIM_F_L2_OC = 3;
  localparam int LDOIM_F_DONE  = 4;
  localparam int LDOIM_NFLAG   = 5;
  localparam int LDOIM_RES_W   = 9;
  localparam int LDOIM_STEP_MA = 20;
endpackage

// file: rtl/ldoim_sync.sv
// two-stage synchroniser for one asynchronous level
`timescale 1ns/1ps
module ldoim_sync (
  input  wire logic clk,    // device clock
  input  wire logic rst_b,  // async reset, active low
  input  wire logic d,      // async level
  output logic      q       // synchronised level
);
  logic meta;
  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // ldoim_sync

// file: rtl/ldoim_flag.sv
// sticky event flag: hardware set beats write-one-to-clear
`timescale 1ns/1ps
module ldoim_flag (
  input  wire logic clk,    // device clock
  input  wire logic rst_b,  // async reset, active low
  input  wire logic set,    // event pulse, already gated by mask
  input  wire logic clr,    // write-one-to-clear pulse
  output logic      flag    // sticky flag
);
  // set wins so no event is lost in the clear cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end
endmodule // ldoim_flag

// file: rtl/ldoim_regs.sv
// register bank: regulator event masks, load meter select and result, interrupt out
`timescale 1ns/1ps
//
// Function
// - bit 7 masks lin2 power-good fall
// - bit 6 masks lin2 power-good rise
// - bit 4 masks lin2 overcurrent
// - bit 3 masks lin1 power-good fall
// - bit 2 masks lin1 power-good rise
// - bit 0 masks lin1 overcurrent
// - masks never touch live status bits
// - select bit 0 picks buck one/two
// - select write starts a measurement
// - result msb at 0x25 bit 0
// - result counts 20 mA per step
// - result low byte at next register
// - measurement done raises masked interrupt
module ldoim_regs (
  input  wire logic                              clk,          // 25 MHz device clock
  input  wire logic                              rst_b,        // async reset, active low
  input  wire logic                              reg_wr,       // register write strobe
  input  wire logic                              reg_rd,       // register read strobe
  input  wire logic [7:0]                        reg_addr,     // register address
  input  wire logic [7:0]                        reg_wdata,    // write data
  output logic [7:0]                             reg_rdata,    // read data, registered
  input  wire logic                              lin1_pg_raw,  // lin1 power-good, async
  input  wire logic                              lin2_pg_raw,  // lin2 power-good, async
  input  wire logic                              lin1_oc_raw,  // lin1 current limit, async
  input  wire logic                              lin2_oc_raw,  // lin2 current limit, async
  input  wire logic                              meter_done,   // meter finished, one pulse
  input  wire logic [ldoim_pkg::LDOIM_RES_W-1:0] meter_value,  // result, 20 mA steps
  output logic                                   meter_start,  // one-cycle start pulse
  output logic                                   meter_sel,    // chosen buck
  output logic                                   irq_b         // interrupt, active low
);
  import ldoim_pkg::*;

  logic [7:0]             linear_reg_irq_mask;
  logic [7:0]             load_meter_select;
  logic [LDOIM_RES_W-1:0] result;
  logic                   meter_done_irq_off;
  logic                   lin1_pg_live;
  logic                   lin2_pg_live;
  logic                   lin1_overcurrent_live;
  logic                   lin2_overcurrent_live;
  logic                   lin1_pg_d;
  logic                   lin2_pg_d;
  logic                   lin1_oc_d;
  logic                   lin2_oc_d;
  logic [LDOIM_NFLAG-1:0] ev_set;
  logic [LDOIM_NFLAG-1:0] ev_clr;
  logic [LDOIM_NFLAG-1:0] linear_reg_event_flags;
  logic [7:0]             next_rdata;

  // pins cross into clk domain before any edge logic sees them
  ldoim_sync u_s_l1pg (.clk(clk), .rst_b(rst_b), .d(lin1_pg_raw), .q(lin1_pg_live));
  ldoim_sync u_s_l2pg (.clk(clk), .rst_b(rst_b), .d(lin2_pg_raw), .q(lin2_pg_live));
  ldoim_sync u_s_l1oc (.clk(clk), .rst_b(rst_b), .d(lin1_oc_raw), .q(lin1_overcurrent_live));
  ldoim_sync u_s_l2oc (.clk(clk), .rst_b(rst_b), .d(lin2_oc_raw), .q(lin2_overcurrent_live));

  // previous live values for edge detection
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lin1_pg_d <= 1'b0;
      lin2_pg_d <= 1'b0;
      lin1_oc_d <= 1'b0;
      lin2_oc_d <= 1'b0;
    end else begin
      lin1_pg_d <= lin1_pg_live;
      lin2_pg_d <= lin2_pg_live;
      lin1_oc_d <= lin1_overcurrent_live;
      lin2_oc_d <= lin2_overcurrent_live;
    end
  end

  // mask register; reserved bits held at zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      linear_reg_irq_mask <= LDOIM_MASK_RESET;
    end else if (reg_wr && reg_addr == LDOIM_ADDR_MASK) begin
      linear_reg_irq_mask <= reg_wdata & LDOIM_MASK_WR;
    end
  end

  // top-level meter mask, resets clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meter_done_irq_off <= 1'b0;
    end else if (reg_wr && reg_addr == LDOIM_ADDR_TOPMASK) begin
      meter_done_irq_off <= reg_wdata[0];
    end
  end

  // select register; any write, even same value, restarts the meter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      load_meter_select <= LDOIM_SEL_RESET;
      meter_start       <= 1'b0;
    end else begin
      meter_start <= reg_wr && reg_addr == LDOIM_ADDR_SELECT;
      if (reg_wr && reg_addr == LDOIM_ADDR_SELECT) begin
        load_meter_select <= reg_wdata;
      end
    end
  end

  // buck choice follows the select bit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meter_sel <= 1'b0;
    end else if (reg_wr && reg_addr == LDOIM_ADDR_SELECT) begin
      meter_sel <= reg_wdata[LDOIM_B_SEL];
    end
  end

  // result captured on completion so both bytes stay coherent
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result <= '0;
    end else if (meter_done) begin
      result <= meter_value;
    end
  end

  // gated events: a set mask bit suppresses the flag only, never live state
  always_comb begin
    ev_set = '0;
    ev_set[LDOIM_F_L1_PG] = (lin1_pg_live && !lin1_pg_d
                             && !linear_reg_irq_mask[LDOIM_B_L1_RISE])
                          || (!lin1_pg_live && lin1_pg_d
                             && !linear_reg_irq_mask[LDOIM_B_L1_FALL]);
    ev_set[LDOIM_F_L2_PG] = (lin2_pg_live && !lin2_pg_d
                             && !linear_reg_irq_mask[LDOIM_B_L2_RISE])
                          || (!lin2_pg_live && lin2_pg_d
                             && !linear_reg_irq_mask[LDOIM_B_L2_FALL]);
    ev_set[LDOIM_F_L1_OC] = lin1_overcurrent_live && !lin1_oc_d
                          && !linear_reg_irq_mask[LDOIM_B_L1_OC];
    ev_set[LDOIM_F_L2_OC] = lin2_overcurrent_live && !lin2_oc_d
                          && !linear_reg_irq_mask[LDOIM_B_L2_OC];
    ev_set[LDOIM_F_DONE]  = meter_done && !meter_done_irq_off;
    ev_clr = (reg_wr && reg_addr == LDOIM_ADDR_FLAGS) ? reg_wdata[LDOIM_NFLAG-1:0] : '0;
  end

  // one sticky flag per event source
  genvar gi;
  generate
    for (gi = 0; gi < LDOIM_NFLAG; gi++) begin : g_flag
      ldoim_flag u_flag (
        .clk   (clk),
        .rst_b (rst_b),
        .set   (ev_set[gi]),
        .clr   (ev_clr[gi]),
        .flag  (linear_reg_event_flags[gi])
      );
    end
  endgenerate

  // interrupt reflects current flags; flags are only set when unmasked
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_b <= 1'b1;
    end else begin
      irq_b <= ~(|(linear_reg_event_flags | ev_set));
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      LDOIM_ADDR_MASK:     next_rdata = linear_reg_irq_mask;
      LDOIM_ADDR_SELECT:   next_rdata = load_meter_select;
      LDOIM_ADDR_RES_HIGH: next_rdata[LDOIM_B_MSB] = result[LDOIM_RES_W-1];
      LDOIM_ADDR_RES_LOW:  next_rdata = result[7:0];
      LDOIM_ADDR_FLAGS:    next_rdata[LDOIM_NFLAG-1:0] = linear_reg_event_flags;
      LDOIM_ADDR_LIVE:     next_rdata[3:0] = {lin2_overcurrent_live, lin2_pg_live,
                                              lin1_overcurrent_live, lin1_pg_live};
      LDOIM_ADDR_TOPMASK:  next_rdata[0] = meter_done_irq_off;
      default:             next_rdata = 8'h00;
    endcase
  end

  // read data latched on the read strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // checks
  sequence ldoim_sel_wr_s;
    reg_wr && reg_addr == LDOIM_ADDR_SELECT;
  endsequence

  meter_start_a: assert property (@(posedge clk) disable iff (!rst_b)
    ldoim_sel_wr_s |=> meter_start && meter_sel == $past(reg_wdata[LDOIM_B_SEL]))
    else $error("select write did not start meter");
  start_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
    meter_start |=> !meter_start || $past(reg_wr))
    else $error("start pulse too long");
  l2_fall_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
    (!lin2_pg_live && lin2_pg_d && linear_reg_irq_mask[LDOIM_B_L2_FALL]
     && !linear_reg_event_flags[LDOIM_F_L2_PG]) |=> !linear_reg_event_flags[LDOIM_F_L2_PG])
    else $error("masked lin2 fall set flag");
  l2_rise_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
    (lin2_pg_live && !lin2_pg_d && !linear_reg_irq_mask[LDOIM_B_L2_RISE])
    |=> linear_reg_event_flags[LDOIM_F_L2_PG])
    else $error("lin2 rise lost");
  l2_oc_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
    (lin2_overcurrent_live && !lin2_oc_d && !linear_reg_irq_mask[LDOIM_B_L2_OC])
    |=> linear_reg_event_flags[LDOIM_F_L2_OC])
    else $error("lin2 overcurrent lost");
  l1_fall_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
    (!lin1_pg_live && lin1_pg_d && !linear_reg_irq_mask[LDOIM_B_L1_FALL])
    |=> linear_reg_event_flags[LDOIM_F_L1_PG])
    else $error("lin1 fall lost");
  l1_rise_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
    (lin1_pg_live && !lin1_pg_d && !linear_reg_irq_mask[LDOIM_B_L1_RISE])
    |=> linear_reg_event_flags[LDOIM_F_L1_PG])
    else $error("lin1 rise lost");
  l1_oc_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
    (lin1_overcurrent_live && !lin1_oc_d && !linear_reg_irq_mask[LDOIM_B_L1_OC])
    |=> linear_reg_event_flags[LDOIM_F_L1_OC])
    else $error("lin1 overcurrent lost");
  done_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
    (meter_done && !meter_done_irq_off) |=> linear_reg_event_flags[LDOIM_F_DONE] ##1 !irq_b)
    else $error("meter done not flagged");
  result_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_rd && reg_addr == LDOIM_ADDR_RES_HIGH)
    |=> reg_rdata == {7'h00, $past(result[LDOIM_RES_W-1])})
    else $error("result high byte wrong");
  irq_level_a: assert property (@(posedge clk) disable iff (!rst_b)
    (|linear_reg_event_flags) |=> !irq_b)
    else $error("pending flag without interrupt");

  // masked edges and masked meter done: a clear flag must stay clear, the mask only gates the set path
  // and the opposite edge of the same regulator cannot fall in that cycle
  sequence ldoim_l2_rise_off_s;
    lin2_pg_live && !lin2_pg_d && linear_reg_irq_mask[LDOIM_B_L2_RISE]
    && !linear_reg_event_flags[LDOIM_F_L2_PG];
  endsequence
  sequence ldoim_l2_oc_off_s;
    lin2_overcurrent_live && !lin2_oc_d && linear_reg_irq_mask[LDOIM_B_L2_OC]
    && !linear_reg_event_flags[LDOIM_F_L2_OC];
  endsequence
  sequence ldoim_l1_fall_off_s;
    !lin1_pg_live && lin1_pg_d && linear_reg_irq_mask[LDOIM_B_L1_FALL]
    && !linear_reg_event_flags[LDOIM_F_L1_PG];
  endsequence
  sequence ldoim_l1_rise_off_s;
    lin1_pg_live && !lin1_pg_d && linear_reg_irq_mask[LDOIM_B_L1_RISE]
    && !linear_reg_event_flags[LDOIM_F_L1_PG];
  endsequence
  sequence ldoim_l1_oc_off_s;
    lin1_overcurrent_live && !lin1_oc_d && linear_reg_irq_mask[LDOIM_B_L1_OC]
    && !linear_reg_event_flags[LDOIM_F_L1_OC];
  endsequence
  sequence ldoim_done_off_s;
    meter_done && meter_done_irq_off
    && !linear_reg_event_flags[LDOIM_F_DONE];
  endsequence

  l2_rise_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
    ldoim_l2_rise_off_s |=> !linear_reg_event_flags[LDOIM_F_L2_PG])
    else $error("masked lin2 rise set flag");
  l2_oc_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
    ldoim_l2_oc_off_s |=> !linear_reg_event_flags[LDOIM_F_L2_OC])
    else $error("masked lin2 overcurrent set flag");
  l1_fall_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
    ldoim_l1_fall_off_s |=> !linear_reg_event_flags[LDOIM_F_L1_PG])
    else $error("masked lin1 fall set flag");
  l1_rise_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
    ldoim_l1_rise_off_s |=> !linear_reg_event_flags[LDOIM_F_L1_PG])
    else $error("masked lin1 rise set flag");
  l1_oc_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
    ldoim_l1_oc_off_s |=> !linear_reg_event_flags[LDOIM_F_L1_OC])
    else $error("masked lin1 overcurrent set flag");
  done_mask_a: assert property (@(posedge clk) disable iff (!rst_b)
    ldoim_done_off_s |=> !linear_reg_event_flags[LDOIM_F_DONE])
    else $error("masked meter done set flag");

  // result capture and read-back of result and live state
  result_cap_a: assert property (@(posedge clk) disable iff (!rst_b)
    meter_done |=> result == $past(meter_value))
    else $error("result not captured on completion");
  result_low_a: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_rd && reg_addr == LDOIM_ADDR_RES_LOW) |=> reg_rdata == $past(result[LDOIM_RES_W-2:0]))
    else $error("result low byte wrong");
  live_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_rd && reg_addr == LDOIM_ADDR_LIVE)
    |=> reg_rdata[LDOIM_NFLAG-2:0] == $past({lin2_overcurrent_live, lin2_pg_live,
                                              lin1_overcurrent_live, lin1_pg_live}))
    else $error("live state read wrong");

  // buck choice and interrupt level between events
  sel_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    !(reg_wr && reg_addr == LDOIM_ADDR_SELECT) |=> meter_sel == $past(meter_sel))
    else $error("buck choice moved without a write");
  irq_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
    (linear_reg_event_flags == '0 && ev_set == '0) |=> irq_b)
    else $error("interrupt without pending flag");
endmodule // ldoim_regs

// file: dv/ldoim_host.sv
// host model: register bus master for the mask, load meter and flag registers
`timescale 1ns/1ps
module ldoim_host (
  input  wire logic       clk,        // device clock
  output logic            reg_wr,     // write strobe
  output logic            reg_rd,     // read strobe
  output logic [7:0]      reg_addr,   // register address
  output logic [7:0]      reg_wdata,  // write data
  input  wire logic [7:0] reg_rdata   // read data
);
  // strobes idle low from time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // one-cycle write; released lines show the inverse so stale values cannot pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // read data is taken a full cycle after the strobe edge, where it has settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    @(negedge clk);
    d = reg_rdata;
  endtask
endmodule // ldoim_host

// file: dv/test_ldo_irq_mask_load_meter_regs.sv
// testbench: regulator event masks, load meter select and result, interrupt output
`timescale 1ns/1ps
module test_ldo_irq_mask_load_meter_regs;
  import ldoim_pkg::*;
  logic       clk, rst_b, meter_done, meter_start, meter_sel, irq_b, reg_wr, reg_rd, lv;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_v, hi, d;
  logic [3:0] raw;
  logic [8:0] meter_value, fs;
  logic [31:0] seed;
  int         num_errors, checks_done, i, n;
  int         starts = 0;
  int         mt[6] = '{7, 6, 4, 3, 2, 0};
  int         rt[6] = '{2, 2, 3, 0, 0, 1};
  logic       lt[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  ldoim_regs dut (.clk(clk), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .lin1_pg_raw(raw[0]), .lin2_pg_raw(raw[2]), .lin1_oc_raw(raw[1]), .lin2_oc_raw(raw[3]),
    .meter_done(meter_done), .meter_value(meter_value), .meter_start(meter_start),
    .meter_sel(meter_sel), .irq_b(irq_b));
  ldoim_host host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // start pulses are counted so a missing or doubled pulse shows
  always @(posedge clk) if (meter_start === 1'b1) starts <= starts + 1;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // load current in mA from a 9-bit result
  function automatic logic [15:0] ma(input logic [8:0] v);
    return 16'(v) * 16'(LDOIM_STEP_MA);
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
    host.rd(a, rd_v);
    chk(nm, {8'h00, e}, {8'h00, rd_v});
  endtask
  task automatic done_pulse(input logic [8:0] v);
    @(negedge clk);
    meter_value = v;
    meter_done = 1'b1;
    @(negedge clk);
    meter_done = 1'b0;
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // watchdog at 8000 cycles, well beyond the few hundred cycles the sequence needs
  initial begin
    #(40 * 8000);
    num_errors++;
    summarize();
  end
  initial begin
    rst_b = 1'b0;
    meter_done = 1'b0;
    meter_value = 9'h000;
    raw = 4'h0;
    seed = 32'd63213;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    chk("irq_b reset", 16'h0001, {15'h0, irq_b});
    rc(LDOIM_ADDR_MASK, LDOIM_MASK_RESET, "mask reset");
    rc(LDOIM_ADDR_SELECT, 8'h00, "select reset");
    rc(LDOIM_ADDR_RES_HIGH, 8'h00, "result high reset");
    rc(LDOIM_ADDR_RES_LOW, 8'h00, "result low reset");
    // random mask writes; reserved bits must read zero
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      host.wr(LDOIM_ADDR_MASK, seed[7:0]);
      rc(LDOIM_ADDR_MASK, seed[7:0] & LDOIM_MASK_WR, "mask rw");
    end
    // each select write starts exactly one measurement on the chosen buck
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      d = {seed[7:1], i[0]};
      n = starts;
      host.wr(LDOIM_ADDR_SELECT, d);
      repeat (2) @(negedge clk);
      chk("start count", 16'(n + 1), 16'(starts));
      chk("meter_sel", {15'h0, d[0]}, {15'h0, meter_sel});
      rc(LDOIM_ADDR_SELECT, d, "select rw");
    end
    // result halves and scale, with full-scale and msb-only corners
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      meter_value = (i == 0) ? 9'h1ff : (i == 1) ? 9'h100 : seed[8:0];
      done_pulse(meter_value);
      host.wr(LDOIM_ADDR_RES_HIGH, 8'hfe);
      host.wr(LDOIM_ADDR_FLAGS, 8'h10);
      host.rd(LDOIM_ADDR_RES_HIGH, hi);
      chk("result high", {15'h0, meter_value[8]}, {8'h00, hi});
      host.rd(LDOIM_ADDR_RES_LOW, rd_v);
      chk("result ma", ma(meter_value), ma({hi[0], rd_v}));
      if (i == 0) fs = {hi[0], rd_v};
    end
    chk("full scale ma", 16'd10220, ma(fs));
    host.wr(8'h40, 8'hff);
    rc(8'h40, 8'h00, "unmapped read");
    // measurement done raises interrupt unless top mask set
    done_pulse(9'h055);
    repeat (2) @(negedge clk);
    chk("irq_b done", 16'h0000, {15'h0, irq_b});
    rc(LDOIM_ADDR_FLAGS, 8'h10, "done flag");
    host.wr(LDOIM_ADDR_FLAGS, 8'h10);
    repeat (2) @(negedge clk);
    chk("irq_b cleared", 16'h0001, {15'h0, irq_b});
    host.wr(LDOIM_ADDR_TOPMASK, 8'h01);
    done_pulse(9'h0aa);
    repeat (2) @(negedge clk);
    chk("irq_b done masked", 16'h0001, {15'h0, irq_b});
    rc(LDOIM_ADDR_FLAGS, 8'h00, "done flag masked");
    // each mask bit: masked edge sets nothing but live tracks, unmasked edge flags
    for (i = 0; i < 6; i++) begin
      lv = lt[i];
      host.wr(LDOIM_ADDR_MASK, 8'hdd);
      raw[rt[i]] = ~lv;
      repeat (6) @(negedge clk);
      host.wr(LDOIM_ADDR_FLAGS, 8'h1f);
      raw[rt[i]] = lv;
      repeat (6) @(negedge clk);
      rc(LDOIM_ADDR_FLAGS, 8'h00, "masked event");
      rc(LDOIM_ADDR_LIVE, {4'h0, raw}, "live state");
      chk("irq_b masked", 16'h0001, {15'h0, irq_b});
      raw[rt[i]] = ~lv;
      repeat (6) @(negedge clk);
      host.wr(LDOIM_ADDR_MASK, 8'hdd & ~(8'h01 << mt[i]));
      host.wr(LDOIM_ADDR_FLAGS, 8'h1f);
      raw[rt[i]] = lv;
      repeat (6) @(negedge clk);
      rc(LDOIM_ADDR_FLAGS, 8'h01 << rt[i], "unmasked event");
      chk("irq_b event", 16'h0000, {15'h0, irq_b});
      host.wr(LDOIM_ADDR_MASK, 8'hdd);
      raw[rt[i]] = 1'b0;
      repeat (6) @(negedge clk);
      host.wr(LDOIM_ADDR_FLAGS, 8'h1f);
    end
    summarize();
  end
endmodule // test_ldo_irq_mask_load_meter_regs
